// ### rtl/pwmfs_top.sv
`include "pwmfs_defs.svh"

module pwmfs_top (
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	input  pwmfs_pkg::pwmfs_bus_req_type       bus_i,
	output logic      [7:0]                    rd_data_o,
	input  wire logic [pwmfs_pkg::NUM_CH-1:0]  pwm_active_i,
	input  wire logic [pwmfs_pkg::NUM_FLT-1:0] fault_in_i,
	output logic      [pwmfs_pkg::NUM_CH-1:0]  chan_o,
	output logic                               irq_o
);
	import pwmfs_pkg::*;

	logic [NUM_CH-1:0]  sense_q;
	logic               lock_dis_q;
	logic               lock_arm_q;
	logic               flt_ctl_q;
	logic [NUM_FLT-1:0] flt_en_q;
	logic [NUM_CH-1:0]  chan_flt_q;
	logic [1:0]         irq_stat_q;
	logic [1:0]         irq_mask_q;
	logic [7:0]         rd_data_q;
	logic               irq_q;

	logic               wr_sense;
	logic               wr_status;
	logic               wr_mode;
	logic               wr_flt_en;
	logic               wr_chan_flt;
	logic               rd_status;
	logic               rd_irq;
	logic               locked_wr;
	logic [NUM_FLT-1:0] detect;
	logic [NUM_FLT-1:0] flags;
	logic               any_flag;
	logic               flt_level;
	logic [NUM_CH-1:0]  safe;
	logic [7:0]         status_rd;
	logic [1:0]         irq_set;
	pwmfs_flag_ctl_type flag_ctl;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign wr_sense    = bus_i.wr && hit(bus_i.addr, `PWMFS_OFS_SENSE);
	assign wr_status   = bus_i.wr && hit(bus_i.addr, `PWMFS_OFS_STATUS);
	assign wr_mode     = bus_i.wr && hit(bus_i.addr, `PWMFS_OFS_MODE);
	assign wr_flt_en   = bus_i.wr && hit(bus_i.addr, `PWMFS_OFS_FLT_EN);
	assign wr_chan_flt = bus_i.wr && hit(bus_i.addr, `PWMFS_OFS_CHAN_FLT);
	assign rd_status   = bus_i.rd && hit(bus_i.addr, `PWMFS_OFS_STATUS);
	assign rd_irq      = bus_i.rd && hit(bus_i.addr, `PWMFS_OFS_IRQ_STAT);

	// Any attempt on a protected field while locked is dropped and reported
	assign locked_wr = !lock_dis_q && (wr_sense || wr_flt_en || wr_chan_flt
		|| (wr_mode && (bus_i.wdata[`PWMFS_MODE_FLT_CTL] != flt_ctl_q)));

	// Fault inputs are level conditions; filtering lives upstream
	assign detect    = {NUM_FLT{flt_ctl_q}} & flt_en_q & fault_in_i;
	assign flt_level = |detect;
	assign any_flag  = |flags;
	assign safe      = {NUM_CH{flt_ctl_q && any_flag}} & chan_flt_q;

	assign status_rd = {any_flag, !lock_dis_q, flt_level, 1'b0, flags};

	assign flag_ctl.arm      = rd_status;
	assign flag_ctl.clr_all  = wr_status && !bus_i.wdata[`PWMFS_ST_ANY_FLAG];
	assign flag_ctl.clr_bits = {NUM_FLT{wr_status}} & ~bus_i.wdata[NUM_FLT-1:0];

	pwmfs_fault_flags #(
		.N (NUM_FLT)
	) u_flags (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.detect_i  (detect),
		.ctl_i     (flag_ctl),
		.flag_o    (flags)
	);

	pwmfs_out_stage #(
		.N (NUM_CH)
	) u_out (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.active_i  (pwm_active_i),
		.sense_i   (sense_q),
		.safe_i    (safe),
		.chan_o    (chan_o)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sense_q <= `PWMFS_RST_SENSE;
		end else if (wr_sense && lock_dis_q) begin
			sense_q <= bus_i.wdata;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flt_en_q   <= `PWMFS_RST_FLT_EN;
			chan_flt_q <= `PWMFS_RST_CHAN_FLT;
			flt_ctl_q  <= 1'b0;
		end else if (lock_dis_q) begin
			if (wr_flt_en) begin
				flt_en_q <= bus_i.wdata[NUM_FLT-1:0];
			end
			if (wr_chan_flt) begin
				chan_flt_q <= bus_i.wdata;
			end
			if (wr_mode) begin
				flt_ctl_q <= bus_i.wdata[`PWMFS_MODE_FLT_CTL];
			end
		end
	end

	// Unlock needs a status read showing the lock on, so a stray write cannot unlock
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			lock_arm_q <= 1'b0;
		end else if (rd_status && !lock_dis_q) begin
			lock_arm_q <= 1'b1;
		end else if (wr_mode || wr_status) begin
			lock_arm_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			lock_dis_q <= `PWMFS_RST_LOCK_DIS;
		end else if (wr_status && bus_i.wdata[`PWMFS_ST_LOCK_EN]) begin
			lock_dis_q <= 1'b0;
		end else if (wr_mode) begin
			if (!bus_i.wdata[`PWMFS_MODE_LOCK_DIS]) begin
				lock_dis_q <= 1'b0;
			end else if (lock_arm_q) begin
				lock_dis_q <= 1'b1;
			end
		end
	end

	assign irq_set[`PWMFS_IRQ_FAULT]     = |(detect & ~flags);
	assign irq_set[`PWMFS_IRQ_LOCKED_WR] = locked_wr;

	// Read clears, but an event in the same cycle stays set
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_stat_q <= 2'h0;
		end else if (rd_irq) begin
			irq_stat_q <= irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_mask_q <= `PWMFS_RST_MASK;
		end else if (bus_i.wr && hit(bus_i.addr, `PWMFS_OFS_IRQ_MASK)) begin
			irq_mask_q <= bus_i.wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign irq_o = irq_q;

	// Unmapped reads and idle cycles return zero
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rd_data_q <= 8'h00;
		end else if (!bus_i.rd) begin
			rd_data_q <= 8'h00;
		end else begin
			case (bus_i.addr)
				`PWMFS_OFS_SENSE: begin
					rd_data_q <= sense_q;
				end
				`PWMFS_OFS_STATUS: begin
					rd_data_q <= status_rd;
				end
				`PWMFS_OFS_MODE: begin
					rd_data_q <= {6'h00, flt_ctl_q, lock_dis_q};
				end
				`PWMFS_OFS_FLT_EN: begin
					rd_data_q <= {4'h0, flt_en_q};
				end
				`PWMFS_OFS_CHAN_FLT: begin
					rd_data_q <= chan_flt_q;
				end
				`PWMFS_OFS_IRQ_STAT: begin
					rd_data_q <= {6'h00, irq_stat_q};
				end
				`PWMFS_OFS_IRQ_MASK: begin
					rd_data_q <= {6'h00, irq_mask_q};
				end
				default: begin
					rd_data_q <= 8'h00;
				end
			endcase
		end
	end

	assign rd_data_o = rd_data_q;
endmodule // pwmfs_top

// ### common/pwmfs_defs.svh
`ifndef PWMFS_DEFS_SVH
`define PWMFS_DEFS_SVH
// Summary of operation
// - Sense bit per channel: 0 gives active-high output, 1 gives active-low output.
// - Sense bits take writes only while the write lock disable control is 1.
// - Under enabled fault control and a detected fault, affected channels drive their sense value.
// - Status bit 7 reads as the OR of all per-input fault flags.
// - Combined flag clears by status read while set, then writing 0 with no fault present.
// - Writing 1 to the combined fault flag leaves it unchanged.
// - A new fault between the read and the clearing write restarts the sequence.
// - Clearing every per-input flag one by one also clears the combined flag.
// - Status bit 6 always reads as the inverse of the write lock disable control.
// - Writing 1 to the write lock enable bit turns protection on.
// - Protection is turned off by reading enable as 1, then writing 1 to disable.
// - Writing 0 to the write lock enable bit has no effect.
// - Protected bits change only while the write lock enable bit reads 0.
// - A per-input flag sets when fault control, its input enable and its fault are present.
// - Status bit 5 shows the OR of enabled fault inputs while fault control is on.
// - Per-input flag clears by read then writing 0 without fault; 1 ignored; clear-all clears it.

// Register offsets on the plain port
`define PWMFS_OFS_SENSE     8'h24
`define PWMFS_OFS_STATUS    8'h25
`define PWMFS_OFS_MODE      8'h26
`define PWMFS_OFS_FLT_EN    8'h27
`define PWMFS_OFS_CHAN_FLT  8'h28
`define PWMFS_OFS_IRQ_STAT  8'h29
`define PWMFS_OFS_IRQ_MASK  8'h2a

// Status register fields
`define PWMFS_ST_ANY_FLAG   7
`define PWMFS_ST_LOCK_EN    6
`define PWMFS_ST_FLT_LEVEL  5

// Mode register fields
`define PWMFS_MODE_LOCK_DIS 0
`define PWMFS_MODE_FLT_CTL  1

// Interrupt status fields
`define PWMFS_IRQ_FAULT     0
`define PWMFS_IRQ_LOCKED_WR 1

// Reset values
`define PWMFS_RST_SENSE     8'h00
`define PWMFS_RST_LOCK_DIS  1'b1
`define PWMFS_RST_FLT_EN    4'h0
`define PWMFS_RST_CHAN_FLT  8'hff
`define PWMFS_RST_MASK      2'h0

`endif

// ### common/pwmfs_pkg.sv
package pwmfs_pkg;
	localparam int NUM_CH  = 8;
	localparam int NUM_FLT = 4;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pwmfs_bus_req_type;

	typedef struct packed {
		logic [NUM_FLT-1:0] clr_bits;
		logic               clr_all;
		logic               arm;
	} pwmfs_flag_ctl_type;
endpackage

// ### rtl/pwmfs_fault_flags.sv
module pwmfs_fault_flags #(
	parameter int N = 4
) (
	input  wire logic                           clk_sys_i,
	input  wire logic                           rst_n_i,
	input  wire logic [N-1:0]                   detect_i,
	input  pwmfs_pkg::pwmfs_flag_ctl_type       ctl_i,
	output logic      [N-1:0]                   flag_o
);
	import pwmfs_pkg::*;

	logic [N-1:0] flag_q;
	logic [N-1:0] arm_q;
	logic         arm_all_q;

	assign flag_o = flag_q;

	// Each flag is armed by a status read while set; a detection on its own input disarms it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			arm_q <= '0;
		end else begin
			arm_q <= (arm_q | ({N{ctl_i.arm}} & flag_q)) & ~detect_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			arm_all_q <= 1'b0;
		end else if (|detect_i) begin
			arm_all_q <= 1'b0;
		end else if (ctl_i.arm && (|flag_q)) begin
			arm_all_q <= 1'b1;
		end
	end

	// Detection wins over any clear in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flag_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (detect_i[i]) begin
					flag_q[i] <= 1'b1;
				end else if (ctl_i.clr_all && arm_all_q) begin
					flag_q[i] <= 1'b0;
				end else if (ctl_i.clr_bits[i] && arm_q[i]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	end
endmodule // pwmfs_fault_flags

// ### rtl/pwmfs_out_stage.sv
module pwmfs_out_stage #(
	parameter int N = 8
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	input  wire logic [N-1:0] active_i,
	input  wire logic [N-1:0] sense_i,
	input  wire logic [N-1:0] safe_i,
	output logic      [N-1:0] chan_o
);
	import pwmfs_pkg::*;

	logic [N-1:0] chan_q;

	assign chan_o = chan_q;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			chan_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (safe_i[i]) begin
					chan_q[i] <= sense_i[i];
				end else begin
					chan_q[i] <= active_i[i] ^ sense_i[i];
				end
			end
		end
	end
endmodule // pwmfs_out_stage

// ### verif/pwmfs_checker.sv
module pwmfs_checker (
	input wire logic                    clk_sys_i,
	input wire logic                    rst_n_i,
	input pwmfs_pkg::pwmfs_bus_req_type bus_i,
	input wire logic [7:0]              rd_data_o,
	input wire logic [7:0]              pwm_active_i,
	input wire logic [3:0]              fault_in_i,
	input wire logic [7:0]              chan_o,
	input wire logic                    irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import pwmfs_pkg::*;
	wire rs = bus_i.rd && bus_i.addr == 8'h25;
	wire ws = bus_i.wr && bus_i.addr == 8'h25;
	wire w6 = bus_i.wr && bus_i.addr == 8'h26;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	chk_read_idle: assert property (
		!bus_i.rd |=> rd_data_o == 8'h00) else $error("read data outside answer");
	chk_flag_or: assert property (
		rs |=> rd_data_o[7] == |rd_data_o[3:0]) else $error("combined flag wrong");
	chk_level_quiet: assert property (
		(fault_in_i == 4'h0)[*2] ##0 rs |=> !rd_data_o[5]) else $error("level set");
	chk_lock_set: assert property (
		(ws && bus_i.wdata[6]) ##1 rs |=> rd_data_o[6]) else $error("lock not set");
	chk_mode_lock: assert property (
		(w6 && !bus_i.wdata[0]) ##1 rs |=> rd_data_o[6]) else $error("lock not inverse");
	chk_unlock_seq: assert property (
		rs ##1 (w6 && bus_i.wdata[0]) ##1 rs |=> !rd_data_o[6]) else $error("no unlock");
	chk_lock_wr_zero: assert property (
		rs ##1 (ws && !bus_i.wdata[6]) ##1 rs |=> rd_data_o[6] == $past(rd_data_o[6], 2))
		else $error("lock changed");
	chk_flag_wr_one: assert property (
		rs ##1 (ws && rd_data_o[7] && bus_i.wdata[7] && bus_i.wdata[3:0] == 4'hf) ##1 rs
		|=> rd_data_o[7]) else $error("flag lost on write of one");
	chk_clear_held: assert property (
		rs ##1 (ws && rd_data_o[7] && rd_data_o[5] && $stable(fault_in_i)) ##1 rs
		|=> rd_data_o[7]) else $error("flag cleared under fault");
	cover property (rs ##1 rd_data_o[7]);
	cover property ($rose(irq_o));
	cover property (w6 ##1 rs ##1 !rd_data_o[6]);
endmodule // pwmfs_checker

bind pwmfs_top pwmfs_checker u_chk (.clk_sys_i, .rst_n_i, .bus_i, .rd_data_o,
	.pwm_active_i, .fault_in_i, .chan_o, .irq_o);

// ### verif/pwmfs_fault_src.sv
module pwmfs_fault_src (
	input  wire logic       clk_sys_i,
	input  wire logic [3:0] fault_req_i,
	output logic      [3:0] fault_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Level source: a fault stands until the stage recovers, never a pulse
	always_ff @(posedge clk_sys_i) begin
		fault_o <= fault_req_i;
	end
endmodule // pwmfs_fault_src

// ### verif/tb_pwmfs_top.sv
module tb_pwmfs_top import pwmfs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk_sys_i = 1'b0;
	logic              rst_n_i = 1'b0;
	pwmfs_bus_req_type bus_i = '0;
	logic [7:0]        rd_data_o, chan_o, last;
	logic [7:0]        pwm_active_i = 8'h5a;
	logic [3:0]        fault_in_i, f_req = 4'h0;
	logic              irq_o;
	int                err_count = 0, n_checks = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	pwmfs_top u_dut (.clk_sys_i, .rst_n_i, .bus_i, .rd_data_o, .pwm_active_i,
		.fault_in_i, .chan_o, .irq_o);
	pwmfs_fault_src u_src (.clk_sys_i(clk_sys_i), .fault_req_i(f_req), .fault_o(fault_in_i));
	task chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// A strobe stays up until the next op, so every write is followed by an op
	task op(logic [7:0] a, logic [7:0] d, logic w, logic r);
		@(posedge clk_sys_i);
		bus_i <= '{a, d, w, r};
		#1 last = rd_data_o;
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		op(a, d, 1'b1, 1'b0);
	endtask
	task rs();
		op(8'h25, 8'h00, 1'b0, 1'b1);
	endtask
	task idle(int n);
		repeat (n) op(8'h00, 8'h00, 1'b0, 1'b0);
	endtask
	task rd(logic [7:0] a, logic [7:0] exp, string nm);
		op(a, 8'h00, 1'b0, 1'b1);
		idle(1);
		chk(nm, last, exp);
	endtask
	task t_reset();
		rd(8'h25, 8'h00, "status");
		rd(8'h26, 8'h01, "mode");
		rd(8'h3c, 8'h00, "unmapped");
	endtask
	task t_lock();
		wr(8'h24, 8'h0f);
		idle(3);
		chk("chan", chan_o, 8'h55);
		wr(8'h25, 8'h40);
		rd(8'h25, 8'h40, "locked");
		wr(8'h24, 8'hf0);
		rd(8'h24, 8'h0f, "sense kept");
		wr(8'h27, 8'h0f);
		rd(8'h27, 8'h00, "fault en kept");
		chk("irq masked", {7'h00, irq_o}, 8'h00);
		wr(8'h2a, 8'h02);
		idle(2);
		chk("irq", {7'h00, irq_o}, 8'h01);
		rd(8'h29, 8'h02, "irq stat");
		idle(1);
		chk("irq clr", {7'h00, irq_o}, 8'h00);
		rs();
		wr(8'h25, 8'h00);
		rd(8'h25, 8'h40, "wr0 lock");
		wr(8'h25, 8'h40);
		wr(8'h26, 8'h01);
		rd(8'h25, 8'h40, "no arm");
		rs();
		wr(8'h26, 8'h01);
		rd(8'h25, 8'h00, "unlocked");
		wr(8'h24, 8'hf0);
		rd(8'h24, 8'hf0, "sense new");
		wr(8'h26, 8'h00);
		rd(8'h25, 8'h40, "mode lock");
		rs();
		wr(8'h26, 8'h01);
		wr(8'h2a, 8'h01);
		wr(8'h27, 8'h03);
		wr(8'h26, 8'h03);
		idle(1);
	endtask
	task t_fault();
		f_req <= 4'h5;
		idle(3);
		rd(8'h25, 8'ha1, "fault");
		chk("safe", chan_o, 8'hf0);
		rs();
		wr(8'h25, 8'h00);
		rd(8'h25, 8'ha1, "held");
		f_req <= 4'h0;
		idle(3);
		rs();
		wr(8'h25, 8'h8f);
		rd(8'h25, 8'h81, "wr1");
		rs();
		f_req <= 4'h2;
		idle(2);
		f_req <= 4'h0;
		idle(2);
		wr(8'h25, 8'h0f);
		rd(8'h25, 8'h83, "rearmed");
		chk("irq flt", {7'h00, irq_o}, 8'h01);
		rs();
		wr(8'h25, 8'h00);
		rd(8'h25, 8'h00, "cleared");
		chk("normal", chan_o, 8'haa);
		rd(8'h29, 8'h01, "flt stat");
		f_req <= 4'h3;
		idle(3);
		f_req <= 4'h0;
		idle(3);
		rs();
		wr(8'h25, 8'h8e);
		rd(8'h25, 8'h82, "one");
		rs();
		wr(8'h25, 8'h8d);
		rd(8'h25, 8'h00, "all");
		// Only the low four channels may fall back to their idle level
		wr(8'h28, 8'h0f);
		rd(8'h28, 8'h0f, "chan fault en");
		f_req <= 4'h1;
		idle(3);
		chk("part safe", chan_o, 8'ha0);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_lock();
		t_fault();
		end_of_test();
	end
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule // tb_pwmfs_top
